// file: src/rpic_pkg.sv
// ****************************************************************
// radio phy interrupt controller: shared constants and types
// ****************************************************************
// holds register indices, field positions, reset values, timing and
// the carrier types; assumes one 100 mhz core clock domain.
package rpic_pkg;
    // ****************************************************************
    // bus and register map
    // ****************************************************************
    localparam int ADDR_W = 16;
    localparam int WORD_W = 14;                 // haddr[15:2]
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;
    // register indices; byte address is four times the index
    localparam logic [WORD_W-1:0] IDX_CLEAR_ORDER = 14'h228C;
    localparam logic [WORD_W-1:0] IDX_ENABLE_MASK = 14'h228D;
    localparam logic [WORD_W-1:0] IDX_PRIO_INDEX = 14'h228E;
    localparam logic [WORD_W-1:0] IDX_PENDING = 14'h228F;
    localparam logic [WORD_W-1:0] IDX_PHY_CTRL = 14'h2290;
    localparam logic [WORD_W-1:0] IDX_IRQ_STATUS = 14'h2291;
    localparam logic [WORD_W-1:0] IDX_IRQ_MASK = 14'h2292;
    // ****************************************************************
    // sources and fields
    // ****************************************************************
    localparam int NSRC = 5;
    localparam int SRC_READY = 0;
    localparam int SRC_TX_DONE = 1;
    localparam int SRC_RX_BEGIN = 2;
    localparam int SRC_RX_DONE = 3;
    localparam int SRC_FAIL = 4;
    localparam int NSTS = 6;
    localparam int STS_TX_REFUSED = 5;          // tx request while not allowed
    localparam int FLUSH_BIT = 3;
    localparam int CTRL_PWR_ON_BIT = 0;         // write 1: power-on request
    localparam int CTRL_TX_REQ_BIT = 1;         // write 1: send a packet
    localparam int CTRL_TX_BUSY_BIT = 2;        // read: transmission running
    localparam int CTRL_STATE_LSB = 4;          // read: phy state code
    localparam logic [2:0] IDX_NONE = 3'h7;
    localparam logic [NSRC-1:0] CLEAR_ORDER_RST = 5'h00;
    localparam logic [NSRC-1:0] ENABLE_RST = 5'h00;
    localparam logic [NSRC-1:0] PENDING_RST = 5'h00; // reads back as 0x1f
    localparam logic FLUSH_RST = 1'b1;
    localparam logic [NSTS-1:0] STS_RST = 6'h00;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_NS = 10;
    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_W = 8;
    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        P_IDLE = 2'h0,
        P_PLL = 2'h1,
        P_READY = 2'h3,
        P_STUCK = 2'h2
    } rpic_phy_state_t;
    typedef enum logic [1:0] {
        T_IDLE = 2'h0,
        T_RUN = 2'h1,
        T_DEFER = 2'h3
    } rpic_tx_state_t;
    typedef struct packed {
        logic sel;
        logic write;
        logic [WORD_W-1:0] word;
    } rpic_aphase_t;
endpackage : rpic_pkg

// file: src/rpic_top.sv
// radio phy interrupt controller with ahb-lite register slave
// assumes a single-master ahb-lite bus on mclk and modem status
// inputs that are already synchronous to mclk.
//
// How it works
// R1 - tx done event after packet fully sent
// R2 - no new transmission while one runs
// R3 - busy channel defers tx done until idle
// R4 - ready event when settled after power-on
// R5 - starts idle; ready needed before tx/rx
// R6 - unlocked pll: fail event, stay pll state; the code moves to the stuck state
// R7 - priority ready, tx, rx begin, rx done, fail
// R8 - index field shows highest pending source
// R9 - index read clears sources in priority order
// R10 - simultaneous events queued, handed out sequentially
// R11 - flush bit resets 1; writing 0 clears all
// R12 - enable bits gate sources, reset zero
// R13 - software should keep rx begin disabled
// R14 - clear order bits join clear command
// R15 - pending field reads ones; write 1 acknowledges
// R16 - rx begin event on frame delimiter
// R17 - rx done event on last byte stored
// R18 - irq high while enabled source pending
// R19 - disabled source never queued nor indexed; the code gates only new events, already pending ones stay indexed
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module rpic_top
    import rpic_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // modem status, same clock domain
    input wire logic pll_lock,
    input wire logic chan_busy,
    input wire logic tx_sent,
    input wire logic sfd_detect,
    input wire logic rx_last_stored,
    // modem control and interrupt line
    output logic phy_is_ready,
    output logic tx_launch,
    output logic irq
);
    // ****************************************************************
    // helper functions
    // ****************************************************************
    // lowest set bit wins, so bit order is priority order
    function automatic logic [2:0] prio_idx(input logic [NSRC-1:0] p);
        logic [2:0] r;
        r = IDX_NONE;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (p[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : prio_idx
    // one hot of an index; the empty code 7 falls off the end to zero
    function automatic logic [NSRC-1:0] idx_onehot(input logic [2:0] k);
        return NSRC'(1) << k;
    endfunction : idx_onehot
    // ****************************************************************
    // state
    // ****************************************************************
    rpic_aphase_t ap_reg, ap_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [NSRC-1:0] order_reg, order_next;
    logic [NSRC-1:0] enable_reg, enable_next;
    logic [NSRC-1:0] pend_reg, pend_next;
    logic flush_reg, flush_next;
    logic [NSTS-1:0] sts_reg, sts_next;
    logic [NSTS-1:0] msk_reg, msk_next;
    rpic_phy_state_t phy_reg, phy_next;
    rpic_tx_state_t tx_reg, tx_next;
    logic [SETTLE_W-1:0] settle_reg, settle_next;
    logic ready_reg, ready_next;
    logic launch_reg, launch_next;
    logic irq_reg, irq_next;
    // decoded bus strobes, priority index and event nets
    logic take;
    logic rd_index;
    logic wr_en;
    logic pwr_req;
    logic tx_req;
    logic [2:0] cur_idx;
    logic [NSRC-1:0] raw_evt;
    logic [NSRC-1:0] set_evt;
    logic [NSRC-1:0] clr_evt;
    logic tx_refused;
    logic ev_ready, ev_fail, ev_tx_done; // one driving process each
    // ****************************************************************
    // ahb-lite slave
    // ****************************************************************
    // zero wait states: read data is computed in the address phase so
    // hrdata comes straight from a flop in the data phase
    always_comb begin
        take = hsel & hready & (htrans == HTRANS_NONSEQ) & (hsize == HSIZE_WORD);
        ap_next.sel = take;
        ap_next.write = hwrite;
        ap_next.word = haddr[ADDR_W-1:2];
        rd_index = take & ~hwrite & (haddr[ADDR_W-1:2] == IDX_PRIO_INDEX);
        wr_en = ap_reg.sel & ap_reg.write;
        rdata_next = '0;
        if (take & ~hwrite) begin
            case (haddr[ADDR_W-1:2])
                IDX_CLEAR_ORDER: rdata_next[NSRC-1:0] = order_reg;
                IDX_ENABLE_MASK: rdata_next[NSRC-1:0] = enable_reg;
                IDX_PRIO_INDEX: rdata_next[FLUSH_BIT:0] = {flush_reg, cur_idx}; // R8
                IDX_PENDING: rdata_next[NSRC-1:0] = ~pend_reg; // R15
                IDX_PHY_CTRL: begin
                    rdata_next[CTRL_TX_BUSY_BIT] = (tx_reg != T_IDLE);
                    rdata_next[CTRL_STATE_LSB+:2] = phy_reg;
                end
                IDX_IRQ_STATUS: rdata_next[NSTS-1:0] = sts_reg;
                IDX_IRQ_MASK: rdata_next[NSTS-1:0] = msk_reg;
                default: rdata_next = '0; // unmapped reads as zero, okay
            endcase
        end
        pwr_req = wr_en & (ap_reg.word == IDX_PHY_CTRL) & hwdata[CTRL_PWR_ON_BIT];
        tx_req = wr_en & (ap_reg.word == IDX_PHY_CTRL) & hwdata[CTRL_TX_REQ_BIT];
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            ap_reg <= '0;
            rdata_reg <= '0;
        end else begin
            ap_reg <= ap_next;
            rdata_reg <= rdata_next;
        end
    end

    // ****************************************************************
    // phy power-up sequencing
    // ****************************************************************
    // pll lock is judged at the end of the settle interval; a failed
    // attempt parks in the stuck state until software asks again
    always_comb begin
        phy_next = phy_reg;
        settle_next = settle_reg;
        ev_ready = 1'b0;
        ev_fail = 1'b0;
        case (phy_reg)
            P_IDLE: begin
                if (pwr_req) begin // R5
                    phy_next = P_PLL;
                    settle_next = '0;
                end
            end
            P_PLL: begin
                if (settle_reg == SETTLE_W'(SETTLE_CYCLES - 1)) begin
                    if (pll_lock) begin
                        phy_next = P_READY;
                        ev_ready = 1'b1; // R4
                    end else begin
                        phy_next = P_STUCK;
                        ev_fail = 1'b1; // R6
                    end
                end else begin
                    settle_next = settle_reg + 1'b1;
                end
            end
            P_STUCK: begin
                if (pwr_req) begin // R6
                    phy_next = P_PLL;
                    settle_next = '0;
                end
            end
            P_READY: phy_next = P_READY;
            default: phy_next = P_IDLE;
        endcase
        ready_next = (phy_next == P_READY);
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            phy_reg <= P_IDLE;
            settle_reg <= '0;
            ready_reg <= 1'b0;
        end else begin
            phy_reg <= phy_next;
            settle_reg <= settle_next;
            ready_reg <= ready_next;
        end
    end

    // ****************************************************************
    // transmit tracking
    // ****************************************************************
    // a request during a running packet or before ready is dropped and
    // flagged, never queued, so the modem sees one launch per packet
    always_comb begin
        tx_next = tx_reg;
        launch_next = 1'b0;
        ev_tx_done = 1'b0;
        tx_refused = 1'b0;
        case (tx_reg)
            T_IDLE: begin
                if (tx_req & ready_reg) begin // R5
                    tx_next = T_RUN;
                    launch_next = 1'b1;
                end else begin
                    tx_refused = tx_req;
                end
            end
            T_RUN: begin
                tx_refused = tx_req; // R2
                if (tx_sent) begin
                    if (chan_busy) begin
                        tx_next = T_DEFER; // R3
                    end else begin
                        tx_next = T_IDLE;
                        ev_tx_done = 1'b1; // R1
                    end
                end
            end
            T_DEFER: begin
                tx_refused = tx_req; // R2
                if (~chan_busy) begin
                    tx_next = T_IDLE;
                    ev_tx_done = 1'b1; // R3
                end
            end
            default: tx_next = T_IDLE;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_reg <= T_IDLE;
            launch_reg <= 1'b0;
        end else begin
            tx_reg <= tx_next;
            launch_reg <= launch_next;
        end
    end

    // ****************************************************************
    // pending queue, index and configuration
    // ****************************************************************
    // internally a pending source is a 1; software sees it as 0.
    // set wins over every clear in the same cycle, so no event is lost
    always_comb begin
        raw_evt = {ev_fail, 2'b00, ev_tx_done, ev_ready}; // fail highest bit, ready lowest
        raw_evt[SRC_RX_BEGIN] = sfd_detect & ready_reg; // R16
        raw_evt[SRC_RX_DONE] = rx_last_stored & ready_reg; // R17
        set_evt = raw_evt & enable_reg; // R12 R19
        cur_idx = prio_idx(pend_reg); // R7 R8
        clr_evt = '0;
        if (rd_index && cur_idx != IDX_NONE) begin
            clr_evt = idx_onehot(cur_idx) | (order_reg & pend_reg); // R9 R14
        end
        order_next = order_reg;
        enable_next = enable_reg;
        flush_next = flush_reg;
        msk_next = msk_reg;
        if (wr_en) begin
            case (ap_reg.word)
                IDX_CLEAR_ORDER: order_next = hwdata[NSRC-1:0];
                IDX_ENABLE_MASK: enable_next = hwdata[NSRC-1:0];
                IDX_PRIO_INDEX: begin
                    flush_next = hwdata[FLUSH_BIT];
                    if (~hwdata[FLUSH_BIT]) begin
                        clr_evt = {NSRC{1'b1}}; // R11
                    end
                end
                IDX_PENDING: clr_evt = clr_evt | hwdata[NSRC-1:0]; // R15
                IDX_IRQ_MASK: msk_next = hwdata[NSTS-1:0];
                default: clr_evt = clr_evt;
            endcase
        end
        pend_next = (pend_reg & ~clr_evt) | set_evt; // R10
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            order_reg <= CLEAR_ORDER_RST;
            enable_reg <= ENABLE_RST;
            flush_reg <= FLUSH_RST;
            msk_reg <= STS_RST;
            pend_reg <= PENDING_RST;
        end else begin
            order_reg <= order_next;
            enable_reg <= enable_next;
            flush_reg <= flush_next;
            msk_reg <= msk_next;
            pend_reg <= pend_next;
        end
    end

    // ****************************************************************
    // sticky status, mask and interrupt line
    // ****************************************************************
    // write one to clear; a new event in the clearing cycle stays set
    always_comb begin
        sts_next = sts_reg;
        if (wr_en && ap_reg.word == IDX_IRQ_STATUS) begin
            sts_next = sts_reg & ~hwdata[NSTS-1:0];
        end
        sts_next = sts_next | {tx_refused, set_evt};
        irq_next = (|pend_next) | (|(sts_next & msk_next)); // R18
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            sts_reg <= STS_RST;
            irq_reg <= 1'b0;
        end else begin
            sts_reg <= sts_next;
            irq_reg <= irq_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // the slave never stalls and always answers okay; both come from flops
    // so no input reaches an output pin combinationally
    logic hready_reg, hresp_reg;
    always_ff @(posedge mclk) begin
        hready_reg <= 1'b1;
        hresp_reg <= HRESP_OKAY;
    end
    assign hrdata = rdata_reg;
    assign hreadyout = hready_reg;
    assign hresp = hresp_reg;
    assign phy_is_ready = ready_reg;
    assign tx_launch = launch_reg;
    assign irq = irq_reg;
endmodule : rpic_top

// file: sim/rpic_properties.sv
// checker for the phy interrupt controller, bound to rpic_top
// assumes one mclk domain with synchronous active-high rst
`timescale 1ns/1ps
module rpic_properties
    import rpic_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // bus side
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // modem side
    input wire logic pll_lock,
    input wire logic chan_busy,
    input wire logic tx_sent,
    input wire logic sfd_detect,
    input wire logic rx_last_stored,
    input wire logic phy_is_ready,
    input wire logic tx_launch,
    input wire logic irq
);
    // ****************************************************************
    // shadow state
    // ****************************************************************
    logic wa_reg, wa_next, tx_reg, tx_next, df_reg, df_next;
    logic [4:0] en_reg, en_next;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // snoop enable writes; the shadow lags one data phase, as the design does
    always_comb begin
        wa_next = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD && hwrite
            && haddr == {IDX_ENABLE_MASK, 2'b00};
        en_next = wa_reg ? hwdata[4:0] : en_reg;
        tx_next = tx_launch ? 1'b1 : (tx_sent ? 1'b0 : tx_reg);
        df_next = (tx_reg && tx_sent && chan_busy) || (df_reg && chan_busy);
    end
    // register the shadow
    always_ff @(posedge mclk) begin
        wa_reg <= rst ? 1'b0 : wa_next;
        en_reg <= rst ? 5'h00 : en_next;
        tx_reg <= rst ? 1'b0 : tx_next;
        df_reg <= rst ? 1'b0 : df_next;
    end
    // ****************************************************************
    // assertions
    // ****************************************************************
    chk_launch_when_ready: assert property (tx_launch |-> phy_is_ready)
        else $error("tx launch while phy not ready");
    chk_no_overlap_tx: assert property (tx_launch |-> !tx_reg && !df_reg)
        else $error("tx launch during a transmission");
    chk_launch_single: assert property (tx_launch |=> !tx_launch)
        else $error("tx launch longer than one cycle");
    chk_tx_done_irq: assert property (tx_reg && tx_sent && !chan_busy && en_reg[1] |-> ##[1:2] irq)
        else $error("no irq after tx done");
    chk_defer_release: assert property (df_reg && !chan_busy && en_reg[1] |-> ##[1:2] irq)
        else $error("no irq after deferred tx done");
    chk_ready_irq: assert property ($rose(phy_is_ready) && en_reg[0] |-> ##[0:1] irq)
        else $error("no irq on phy ready");
    chk_rx_begin_irq: assert property (phy_is_ready && sfd_detect && en_reg[2] |-> ##[1:2] irq)
        else $error("no irq on frame delimiter");
    chk_rx_done_irq: assert property (phy_is_ready && rx_last_stored && en_reg[3] |-> ##[1:2] irq)
        else $error("no irq on last byte stored");
    chk_irq_quiet: assert property ($fell(rst) |-> !irq [*2])
        else $error("irq high after reset");
    cov_tx: cover property (tx_launch);
    cov_defer: cover property (df_reg && !chan_busy);
    cov_ready: cover property ($rose(phy_is_ready));
endmodule : rpic_properties

// file: sim/rpic_modem_model.sv
// behavioural modem stub driving the status inputs of rpic_top
// assumes mclk domain; the bench picks lock outcome and channel load
`timescale 1ns/1ps
module rpic_modem_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // from the design
    input wire logic tx_launch,
    input wire logic phy_is_ready,
    // bench commands
    input wire logic lock_ok,
    input wire logic busy_mode,
    input wire logic rx_go,
    // status to the design
    output logic pll_lock,
    output logic chan_busy,
    output logic tx_sent,
    output logic sfd_detect,
    output logic rx_last_stored
);
    // ****************************************************************
    // modem behaviour
    // ****************************************************************
    assign pll_lock = lock_ok;
    // air time, then the channel may stay busy past the end of the packet
    always @(posedge mclk) begin
        if (rst) begin
            chan_busy <= 1'b0;
            tx_sent <= 1'b0;
        end else if (tx_launch) begin
            repeat (8) @(posedge mclk);
            chan_busy <= busy_mode;
            tx_sent <= 1'b1;
            @(posedge mclk);
            tx_sent <= 1'b0;
            repeat (4) @(posedge mclk);
            chan_busy <= 1'b0;
        end
    end
    // delimiter and last byte land together to exercise queueing
    always @(posedge mclk) begin
        sfd_detect <= rx_go && phy_is_ready;
        rx_last_stored <= rx_go && phy_is_ready;
    end
endmodule : rpic_modem_model

// file: sim/tb_radio_phy_irq_controller.sv
// self-checking bench: ahb-lite register calls against rpic_top
// assumes the modem stub and the bound property checker
`timescale 1ns/1ps
module tb_radio_phy_irq_controller
    import rpic_pkg::*;
;
    // ****************************************************************
    // signals and tasks
    // ****************************************************************
    localparam logic [15:0] A_ORD = 16'h8A30;
    localparam logic [15:0] A_EN = 16'h8A34;
    localparam logic [15:0] A_IDX = 16'h8A38;
    localparam logic [15:0] A_PND = 16'h8A3C;
    localparam logic [15:0] A_CTL = 16'h8A40;
    localparam logic [15:0] A_STS = 16'h8A44;
    logic mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, lock_ok = 1'b0, busy_mode = 1'b0, rx_go = 1'b0;
    logic [15:0] haddr = 16'h0000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0000_0000, hrdata, rd;
    logic hreadyout, hresp, pll_lock, chan_busy, tx_sent, sfd_detect, rx_last_stored, phy_is_ready, tx_launch, irq;
    int err_total = 0, n_checks = 0, cyc = 0;
    rpic_top #(.SETTLE_CYCLES(4)) i_rpic_top (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pll_lock(pll_lock), .chan_busy(chan_busy), .tx_sent(tx_sent), .sfd_detect(sfd_detect),
        .rx_last_stored(rx_last_stored), .phy_is_ready(phy_is_ready), .tx_launch(tx_launch), .irq(irq));
    rpic_modem_model i_rpic_modem_model (.mclk(mclk), .rst(rst), .tx_launch(tx_launch), .phy_is_ready(phy_is_ready),
        .lock_ok(lock_ok), .busy_mode(busy_mode), .rx_go(rx_go), .pll_lock(pll_lock), .chan_busy(chan_busy),
        .tx_sent(tx_sent), .sfd_detect(sfd_detect), .rx_last_stored(rx_last_stored));
    initial begin
        forever #5 mclk = ~mclk;
    end
    // one single word transfer; waits on hready in both phases
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic rdc(input string n, input logic [15:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(n, rd, e);
    endtask : rdc
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask : idle
    // one received packet: delimiter and last byte in the same cycle
    task automatic rx_pkt;
        rx_go <= 1'b1;
        @(posedge mclk);
        rx_go <= 1'b0;
        idle(3);
    endtask : rx_pkt
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    // hang guard; the whole sequence needs well under a thousand cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            end_sim();
        end
    end
    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        idle(8);
        rst <= 1'b0;
        @(posedge mclk);
        rdc("order", A_ORD, 32'h0000_0000);
        rdc("enable", A_EN, 32'h0000_0000);
        rdc("index", A_IDX, 32'h0000_000F);
        rdc("pending", A_PND, 32'h0000_001F);
        rdc("unmapped", 16'h0100, 32'h0000_0000);
        chk("ready_resp", {30'h0, hreadyout, hresp}, 32'h0000_0002);
        chk("irq", {31'h0, irq}, 32'h0000_0000);
        bus(1'b1, A_EN, 32'h0000_001F);
        rdc("enable", A_EN, 32'h0000_001F);
        // power-on with the pll never locking: fail event, stuck state
        bus(1'b1, A_CTL, 32'h0000_0001);
        idle(10);
        chk("irq", {31'h0, irq}, 32'h0000_0001);
        bus(1'b0, A_CTL, 32'h0000_0000);
        chk("state", {30'h0, rd[5:4]}, 32'h0000_0002);
        rdc("index", A_IDX, 32'h0000_000C);
        rdc("index", A_IDX, 32'h0000_000F);
        chk("irq", {31'h0, irq}, 32'h0000_0000);
        // retry with lock held
        lock_ok <= 1'b1;
        bus(1'b1, A_CTL, 32'h0000_0001);
        idle(10);
        chk("ready", {31'h0, phy_is_ready}, 32'h0000_0001);
        bus(1'b0, A_CTL, 32'h0000_0000);
        chk("state", {30'h0, rd[5:4]}, 32'h0000_0003);
        // send on a busy channel; a second request overlaps and is refused
        busy_mode <= 1'b1;
        bus(1'b1, A_CTL, 32'h0000_0002);
        bus(1'b1, A_CTL, 32'h0000_0002);
        rdc("status", A_STS, 32'h0000_0031);
        bus(1'b1, A_STS, 32'h0000_003F);
        idle(20);
        rx_pkt();
        rdc("pending", A_PND, 32'h0000_0010);
        for (int i = 0; i < 4; i++) begin
            rdc("index", A_IDX, 32'h0000_0008 + i);
        end
        rdc("index", A_IDX, 32'h0000_000F);
        chk("irq", {31'h0, irq}, 32'h0000_0000);
        // rx begin kept masked, as software is advised to do
        bus(1'b1, A_EN, 32'h0000_001B);
        rx_pkt();
        rdc("index", A_IDX, 32'h0000_000B);
        rdc("index", A_IDX, 32'h0000_000F);
        // clear order: reporting rx begin also clears rx done
        bus(1'b1, A_EN, 32'h0000_001F);
        bus(1'b1, A_ORD, 32'h0000_0008);
        rdc("order", A_ORD, 32'h0000_0008);
        rx_pkt();
        rdc("index", A_IDX, 32'h0000_000A);
        rdc("index", A_IDX, 32'h0000_000F);
        // flush everything by writing zero to the flush bit
        rx_pkt();
        bus(1'b1, A_IDX, 32'h0000_0000);
        rdc("index", A_IDX, 32'h0000_0007);
        bus(1'b1, A_IDX, 32'h0000_0008);
        rdc("pending", A_PND, 32'h0000_001F);
        // acknowledge one source through the pending field
        rx_pkt();
        rdc("pending", A_PND, 32'h0000_0013);
        bus(1'b1, A_PND, 32'h0000_0004);
        rdc("pending", A_PND, 32'h0000_0017);
        rdc("index", A_IDX, 32'h0000_000B);
        // send on a free channel: done event right after the packet
        busy_mode <= 1'b0;
        bus(1'b1, A_CTL, 32'h0000_0002);
        idle(15);
        rdc("index", A_IDX, 32'h0000_0009);
        end_sim();
    end
endmodule : tb_radio_phy_irq_controller
bind rpic_top rpic_properties i_rpic_properties (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pll_lock(pll_lock), .chan_busy(chan_busy), .tx_sent(tx_sent), .sfd_detect(sfd_detect),
    .rx_last_stored(rx_last_stored), .phy_is_ready(phy_is_ready), .tx_launch(tx_launch), .irq(irq));
